//--- core/och_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "och_map.svh"

module och_ctrl #(
  parameter int unsigned TB_CYC        = `OCH_TB_CYC,
  parameter int unsigned POR_TICKS     = `OCH_POR_TICKS,
  parameter int unsigned SS_STEP_TICKS = `OCH_SS_STEP_TICKS,
  parameter int unsigned SET_W         = `OCH_SET_W,
  parameter int unsigned BLANK_CYC     = `OCH_BLANK_CYC,
  parameter int unsigned MIN_CYC       = `OCH_MIN_LS_CYC
)(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  // Supply and enable monitors
  input  wire logic             bias_supply_ok,
  input  wire logic             enable_ok,
  // Set pin comparator: DAC has reached the set pin voltage
  input  wire logic             setpoint_reached,
  // Modulator and current sense
  input  wire logic             sw_period_start,
  input  wire logic             pwm_low_req,
  input  wire logic             sense_over,
  // Converter drive
  output logic                  low_gate_drive,
  output logic                  output_enable,
  output logic                  setpoint_source_en,
  // Threshold and reference DACs
  output logic [SET_W-1:0]      setpoint_code,
  output logic [SET_W:0]        trip_threshold_code,
  output logic [6:0]            softstart_ref,
  // Status
  output logic                  overcurrent_protection_off,
  output logic                  hiccup_active,
  output logic                  dummy_index,
  output logic                  min_pulse_active,
  output logic                  trip_pulse,
  output och_pkg::och_state_t   seq_state
);

  localparam int SS_STEPS = `OCH_SS_STEPS;
  localparam int TB_W     = (TB_CYC > 1) ? $clog2(TB_CYC) : 1;
  localparam int POR_W    = (POR_TICKS > 1) ? $clog2(POR_TICKS) : 1;
  localparam int SUB_W    = (SS_STEP_TICKS > 1) ? $clog2(SS_STEP_TICKS) : 1;
  localparam int OFF_CODE = (`OCH_OCP_OFF_MV * (1 << SET_W)) / `OCH_DAC_FS_MV;
  localparam int MAX_CODE = (`OCH_TRIP_MAX_MV * (1 << SET_W)) / `OCH_DAC_FS_MV;

  if (TB_CYC < 1 || POR_TICKS < 1 || SS_STEP_TICKS < 1 || SET_W < 4 || SET_W > 12)
  begin : g_chk
    $error("och_ctrl: timing counts or set-point width out of range");
  end

  och_lsg_if lsg ();

  och_pulse #(
    .BLANK_CYC (BLANK_CYC),
    .MIN_CYC   (MIN_CYC)
  ) u_pulse (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .clk_en          (clk_en),
    .sw_period_start (sw_period_start),
    .pwm_low_req     (pwm_low_req),
    .sense_over      (sense_over),
    .lsg             (lsg.mon)
  );

  // Doubled set point, clamped to the detectable span
  function automatic logic [SET_W:0] trip_level(input logic [SET_W-1:0] code);
    logic [SET_W:0] dbl;
    dbl = {code, 1'b0};
    if (dbl > (SET_W+1)'(MAX_CODE))
      trip_level = (SET_W+1)'(MAX_CODE);
    else
      trip_level = dbl;
  endfunction

  och_pkg::och_state_t state_reg;
  och_pkg::och_state_t state_next;
  logic [TB_W-1:0]     tb_reg;
  logic [POR_W-1:0]    por_reg;
  logic [SUB_W-1:0]    sub_reg;
  logic [6:0]          ramp_reg;
  logic [SET_W-1:0]    code_reg;
  logic [SET_W:0]      thr_reg;
  logic                off_reg;
  logic                dummy_reg;
  logic                hiccup_reg;
  logic                trip_q_reg;
  logic [6:0]          ref_reg;
  logic                running;
  logic                timed;
  logic                tick;
  logic                ramp_end;
  logic                sample_done;
  logic                trip_now;
  logic                phase_restart;

  assign running  = (state_reg == och_pkg::OCH_ST_SOFTSTART) ||
                    (state_reg == och_pkg::OCH_ST_RUN);
  assign timed    = (state_reg != och_pkg::OCH_ST_OFF) &&
                    (state_reg != och_pkg::OCH_ST_RUN);
  // Own prescaler; the switching period never enters these timings
  assign tick     = timed && (tb_reg == TB_W'(TB_CYC - 1));
  assign ramp_end = tick && (sub_reg == SUB_W'(SS_STEP_TICKS - 1)) &&
                    (ramp_reg == 7'(SS_STEPS - 1));
  // Stops once the DAC meets the set pin, or at full scale for an open pin
  assign sample_done = tick && (setpoint_reached || code_reg == '1);
  assign trip_now    = running && lsg.trip;

  // Detection stays armed through the whole ramp, not just in regulation
  assign lsg.armed  = running && !off_reg;
  assign lsg.run_en = running;

  assign low_gate_drive     = lsg.gate_on;
  assign output_enable      = running && !lsg.trip;
  assign setpoint_source_en = (state_reg == och_pkg::OCH_ST_POR_WAIT) ||
                              (state_reg == och_pkg::OCH_ST_SAMPLE);
  assign setpoint_code      = code_reg;
  assign trip_threshold_code = thr_reg;
  assign softstart_ref      = ref_reg;
  assign overcurrent_protection_off = off_reg;
  assign hiccup_active      = hiccup_reg;
  assign dummy_index        = dummy_reg;
  assign min_pulse_active   = lsg.min_pulse;
  assign trip_pulse         = trip_q_reg;
  assign seq_state          = state_reg;

  assign phase_restart = (state_next != state_reg) ||
                         ((state_reg == och_pkg::OCH_ST_DUMMY) && ramp_end);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      och_pkg::OCH_ST_OFF:
        state_next = och_pkg::OCH_ST_POR_WAIT;
      och_pkg::OCH_ST_POR_WAIT:
        if (tick && por_reg == POR_W'(POR_TICKS - 1))
          state_next = och_pkg::OCH_ST_SAMPLE;
      och_pkg::OCH_ST_SAMPLE:
        if (sample_done)
          state_next = och_pkg::OCH_ST_SOFTSTART;
      och_pkg::OCH_ST_SOFTSTART:
        if (trip_now)
          state_next = och_pkg::OCH_ST_DUMMY;
        else if (ramp_end)
          state_next = och_pkg::OCH_ST_RUN;
      och_pkg::OCH_ST_RUN:
        if (trip_now)
          state_next = och_pkg::OCH_ST_DUMMY;
      och_pkg::OCH_ST_DUMMY:
        // Back to a real start, never to sampling; no retry limit
        if (ramp_end && dummy_reg == 1'(`OCH_DUMMY_COUNT - 1))
          state_next = och_pkg::OCH_ST_SOFTSTART;
      default:
        state_next = och_pkg::OCH_ST_OFF;
    endcase
    // Shutdown wins over everything; re-entry runs full initialization
    if (!bias_supply_ok || !enable_ok)
      state_next = och_pkg::OCH_ST_OFF;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= och_pkg::OCH_ST_OFF;
    else if (clk_en)
      state_reg <= state_next;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      tb_reg <= '0;
    else if (clk_en)
    begin
      if (phase_restart || tick)
        tb_reg <= '0;
      else if (timed)
        tb_reg <= tb_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      por_reg <= '0;
    else if (clk_en)
    begin
      if (phase_restart)
        por_reg <= '0;
      else if (tick && state_reg == och_pkg::OCH_ST_POR_WAIT)
        por_reg <= por_reg + 1'b1;
    end
  end

  // Shared staircase: a dummy time-out is one full ramp with output held off
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sub_reg  <= '0;
      ramp_reg <= 7'h00;
    end
    else if (clk_en)
    begin
      if (phase_restart)
      begin
        sub_reg  <= '0;
        ramp_reg <= 7'h00;
      end
      else if (tick && (state_reg == och_pkg::OCH_ST_SOFTSTART ||
                        state_reg == och_pkg::OCH_ST_DUMMY))
      begin
        if (sub_reg == SUB_W'(SS_STEP_TICKS - 1))
        begin
          sub_reg  <= '0;
          ramp_reg <= ramp_reg + 7'h01;
        end
        else
          sub_reg <= sub_reg + 1'b1;
      end
    end
  end

  // Reference shows the real ramp only; full scale in regulation
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ref_reg <= 7'h00;
    else if (clk_en)
    begin
      if (state_next == och_pkg::OCH_ST_RUN)
        ref_reg <= 7'(SS_STEPS);
      else if (state_next == och_pkg::OCH_ST_SOFTSTART && !phase_restart)
        ref_reg <= (tick && sub_reg == SUB_W'(SS_STEP_TICKS - 1)) ?
                   ramp_reg + 7'h01 : ramp_reg;
      else
        ref_reg <= 7'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      dummy_reg <= 1'b0;
    else if (clk_en)
    begin
      if (state_reg != och_pkg::OCH_ST_DUMMY)
        dummy_reg <= 1'b0;
      else if (ramp_end)
        dummy_reg <= ~dummy_reg;
    end
  end

  // Digital hold: nothing decays, only bias supply loss or a new sampling pass rewrites it
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      code_reg <= SET_W'(`OCH_RST_SETPOINT);
    else if (clk_en)
    begin
      if (!bias_supply_ok)
        code_reg <= SET_W'(`OCH_RST_SETPOINT);
      else if (state_reg == och_pkg::OCH_ST_POR_WAIT)
        code_reg <= SET_W'(`OCH_RST_SETPOINT);
      else if (state_reg == och_pkg::OCH_ST_SAMPLE && tick && !sample_done)
        code_reg <= code_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      thr_reg <= '0;
      off_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      thr_reg <= trip_level(code_reg);
      if (state_reg == och_pkg::OCH_ST_SAMPLE && sample_done)
        off_reg <= code_reg > SET_W'(OFF_CODE);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      hiccup_reg <= 1'b0;
    else if (clk_en)
    begin
      if (trip_now)
        hiccup_reg <= 1'b1;
      else if (state_next == och_pkg::OCH_ST_RUN || state_next == och_pkg::OCH_ST_OFF)
        hiccup_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      trip_q_reg <= 1'b0;
    else if (clk_en)
      trip_q_reg <= trip_now;
  end

endmodule

`default_nettype wire

//--- inc/och_map.svh
`ifndef OCH_MAP_SVH
`define OCH_MAP_SVH

// System clock
`define OCH_CLK_PERIOD_NS 8

// Low-side pulse timing, least times rounded up to whole cycles
`define OCH_BLANK_NS 200
`define OCH_BLANK_CYC ((`OCH_BLANK_NS + `OCH_CLK_PERIOD_NS - 1) / `OCH_CLK_PERIOD_NS)
`define OCH_MIN_LS_NS 425
`define OCH_MIN_LS_CYC ((`OCH_MIN_LS_NS + `OCH_CLK_PERIOD_NS - 1) / `OCH_CLK_PERIOD_NS)
`define OCH_NARROW_LIMIT 3

// Timebase: one set-point DAC step, full-scale sampling spans 3.4ms
`define OCH_SET_W 8
`define OCH_SAMPLE_MAX_NS 3400000
`define OCH_TB_NS (`OCH_SAMPLE_MAX_NS / (1 << `OCH_SET_W))
`define OCH_TB_CYC (`OCH_TB_NS / `OCH_CLK_PERIOD_NS)

// Soft-start staircase and power-on delay, in timebase ticks
`define OCH_SS_NS 6800000
`define OCH_SS_STEPS 64
`define OCH_SS_TICKS (`OCH_SS_NS / `OCH_TB_NS)
`define OCH_SS_STEP_TICKS (`OCH_SS_TICKS / `OCH_SS_STEPS)
`define OCH_POR_DELAY_NS 6800000
`define OCH_POR_TICKS (`OCH_POR_DELAY_NS / `OCH_TB_NS)
`define OCH_DUMMY_COUNT 2

// Set-point DAC scale and trip limits
`define OCH_DAC_FS_MV 400
`define OCH_OCP_OFF_MV 300
`define OCH_TRIP_MAX_MV 475
`define OCH_RST_SETPOINT 0

`endif

//--- inc/och_pkg.sv
package och_pkg;

  typedef enum logic [2:0] {
    OCH_ST_OFF       = 3'h0,
    OCH_ST_POR_WAIT  = 3'h1,
    OCH_ST_SAMPLE    = 3'h2,
    OCH_ST_SOFTSTART = 3'h3,
    OCH_ST_RUN       = 3'h4,
    OCH_ST_DUMMY     = 3'h5
  } och_state_t;

endpackage

//--- inc/och_lsg_if.sv
`timescale 1ns/1ps
`default_nettype none

interface och_lsg_if;
  logic run_en;
  logic armed;
  logic gate_on;
  logic trip;
  logic min_pulse;

  modport ctrl (
    output run_en,
    output armed,
    input  gate_on,
    input  trip,
    input  min_pulse
  );

  modport mon (
    input  run_en,
    input  armed,
    output gate_on,
    output trip,
    output min_pulse
  );
endinterface

`default_nettype wire

//--- core/och_pulse.sv
`timescale 1ns/1ps
`default_nettype none
`include "och_map.svh"

module och_pulse #(
  parameter int unsigned BLANK_CYC = `OCH_BLANK_CYC,
  parameter int unsigned MIN_CYC   = `OCH_MIN_LS_CYC
)(
  // Clock and reset
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  input  wire logic  clk_en,
  // Modulator and sense
  input  wire logic  sw_period_start,
  input  wire logic  pwm_low_req,
  input  wire logic  sense_over,
  // Sequencer side
  och_lsg_if.mon     lsg
);

  localparam int CW = $clog2(MIN_CYC + 1);

  if (BLANK_CYC < 1 || MIN_CYC < 2 || BLANK_CYC >= MIN_CYC)
  begin : g_chk
    $error("och_pulse: blanking must be shorter than the minimum pulse");
  end

  logic          gate_q_reg;
  logic [CW-1:0] blank_reg;
  logic [CW-1:0] width_reg;
  logic [CW-1:0] hold_reg;
  logic [1:0]    narrow_reg;
  logic          wide_reg;
  logic          gate_raw;
  logic          rise;
  logic          force_start;

  // Hold stretches a pulse already high, or inserts one if none came
  assign gate_raw    = lsg.run_en & (pwm_low_req | (hold_reg != '0));
  assign rise        = gate_raw & ~gate_q_reg;
  // Window opens after blanking and closes as the gate falls
  assign lsg.trip    = lsg.armed & sense_over & gate_raw & gate_q_reg & (blank_reg == '0);
  // Gate dropped in the same cycle as the trip, not at period end
  assign lsg.gate_on = gate_raw & ~lsg.trip;
  assign lsg.min_pulse = hold_reg != '0;
  // One narrow period already counted plus the one ending now: force the next
  assign force_start = lsg.run_en & sw_period_start & ~wide_reg
                     & (narrow_reg == 2'(`OCH_NARROW_LIMIT - 2));

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      gate_q_reg <= 1'b0;
    else if (clk_en)
      gate_q_reg <= gate_raw;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      blank_reg <= '0;
    else if (clk_en)
    begin
      if (rise)
        blank_reg <= CW'(BLANK_CYC - 1);
      else if (blank_reg != '0)
        blank_reg <= blank_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      width_reg <= '0;
    else if (clk_en)
    begin
      if (rise)
        width_reg <= CW'(1);
      else if (gate_raw && width_reg != CW'(MIN_CYC))
        width_reg <= width_reg + 1'b1;
    end
  end

  // Wide flag covers the period just ending; a set in the boundary cycle wins
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      wide_reg <= 1'b0;
    else if (clk_en)
    begin
      if (gate_raw && width_reg >= CW'(MIN_CYC - 1))
        wide_reg <= 1'b1;
      else if (sw_period_start)
        wide_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      narrow_reg <= 2'h0;
    else if (clk_en)
    begin
      if (!lsg.run_en || force_start)
        narrow_reg <= 2'h0;
      else if (sw_period_start)
        narrow_reg <= wide_reg ? 2'h0 : narrow_reg + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      hold_reg <= '0;
    else if (clk_en)
    begin
      if (!lsg.run_en)
        hold_reg <= '0;
      else if (force_start)
        hold_reg <= CW'(MIN_CYC);
      else if (hold_reg != '0)
        hold_reg <= hold_reg - 1'b1;
    end
  end

endmodule

`default_nettype wire

//--- tb/och_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module och_ctrl_monitor #(
  parameter int unsigned TB_CYC        = 2,
  parameter int unsigned SS_STEP_TICKS = 1,
  parameter int unsigned SET_W         = 8,
  parameter int unsigned BLANK_CYC     = 25,
  parameter int unsigned MIN_CYC       = 54
)(
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                arst_n,
  // Inputs
  input wire logic                enable_ok,
  input wire logic                bias_supply_ok,
  input wire logic                pwm_low_req,
  input wire logic                sense_over,
  // Outputs
  input wire logic                low_gate_drive,
  input wire logic                output_enable,
  input wire logic                setpoint_source_en,
  input wire logic [SET_W-1:0]    setpoint_code,
  input wire logic [SET_W:0]      trip_threshold_code,
  input wire logic [6:0]          softstart_ref,
  input wire logic                overcurrent_protection_off,
  input wire logic                hiccup_active,
  input wire logic                dummy_index,
  input wire logic                min_pulse_active,
  input wire logic                trip_pulse,
  input wire och_pkg::och_state_t seq_state
);
  localparam int DUM_CYC = 2 * 64 * SS_STEP_TICKS * TB_CYC;
  localparam och_pkg::och_state_t ST_SS  = och_pkg::OCH_ST_SOFTSTART;
  localparam och_pkg::och_state_t ST_RUN = och_pkg::OCH_ST_RUN;
  localparam och_pkg::och_state_t ST_DUM = och_pkg::OCH_ST_DUMMY;

  logic       run_w;
  logic [7:0] gate_cnt_reg;
  logic [7:0] hold_cnt_reg;
  logic [15:0] dum_cnt_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  assign run_w = (seq_state == ST_SS || seq_state == ST_RUN) && enable_ok && bias_supply_ok;

  // Saturates so a gate held on for long never wraps back into the blanking span
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      gate_cnt_reg <= 8'h00;
    else
      gate_cnt_reg <= low_gate_drive ? gate_cnt_reg + {7'h00, gate_cnt_reg != 8'hFF} : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      hold_cnt_reg <= 8'h00;
    else
      hold_cnt_reg <= min_pulse_active ? hold_cnt_reg + 8'h01 : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      dum_cnt_reg <= 16'h0000;
    else
      dum_cnt_reg <= (seq_state == ST_DUM) ? dum_cnt_reg + 16'h0001 : 16'h0000;

  sequence s_leave_dummy;
    $past(seq_state) == ST_DUM && seq_state != ST_DUM && $past(enable_ok) && $past(bias_supply_ok);
  endsequence

  sequence s_enter_run;
    $past(seq_state) == ST_SS && seq_state == ST_RUN;
  endsequence

  a_trip_kills_output: assert property (
    run_w && !overcurrent_protection_off && pwm_low_req && sense_over && gate_cnt_reg >= BLANK_CYC
    |-> !output_enable && !low_gate_drive ##1 seq_state == ST_DUM && trip_pulse)
    else $error("accepted trip did not shut the output");
  a_blank_ignores_sense: assert property (
    run_w && pwm_low_req && gate_cnt_reg != 8'h00 && gate_cnt_reg < BLANK_CYC |-> low_gate_drive)
    else $error("gate dropped inside blanking");
  a_trip_enters_dummy: assert property (
    $rose(trip_pulse) |-> seq_state == ST_DUM && !dummy_index && hiccup_active && !output_enable)
    else $error("trip did not start the first dummy time-out");
  a_dummy_then_start: assert property (
    s_leave_dummy |-> seq_state == ST_SS && $past(dummy_index))
    else $error("dummy time-outs did not end in a real start");
  a_dummy_span_exact: assert property (
    s_leave_dummy |-> dum_cnt_reg + 2 >= DUM_CYC && dum_cnt_reg <= DUM_CYC + 2)
    else $error("dummy time-outs have the wrong length");
  a_setpoint_kept_hiccup: assert property (
    hiccup_active |-> $stable(setpoint_code))
    else $error("set point changed during hiccup");
  a_sample_gate_off: assert property (
    seq_state == och_pkg::OCH_ST_SAMPLE |-> setpoint_source_en && !low_gate_drive)
    else $error("gate driven or source off while sampling");
  a_threshold_double: assert property (
    seq_state == ST_RUN |-> trip_threshold_code ==
      ((setpoint_code > 8'h98) ? 9'h130 : {setpoint_code, 1'b0}))
    else $error("threshold is not the clamped double");
  a_protection_off_flag: assert property (
    seq_state == ST_RUN |-> overcurrent_protection_off == (setpoint_code > 8'hC0) && (
      !overcurrent_protection_off || !trip_pulse))
    else $error("protection off flag wrong");
  a_ramp_reaches_top: assert property (
    s_enter_run |-> softstart_ref == 7'h40)
    else $error("reference not full scale in run");
  a_ramp_single_step: assert property (
    $past(seq_state) == ST_SS && seq_state == ST_SS |->
      softstart_ref == $past(softstart_ref) || softstart_ref == $past(softstart_ref) + 7'h01)
    else $error("reference jumped more than one step");
  a_min_pulse_width: assert property (
    $fell(min_pulse_active) && seq_state == ST_RUN |-> hold_cnt_reg == MIN_CYC)
    else $error("forced pulse width wrong");
endmodule

bind och_ctrl och_ctrl_monitor #(
  .TB_CYC(TB_CYC), .SS_STEP_TICKS(SS_STEP_TICKS), .SET_W(SET_W),
  .BLANK_CYC(BLANK_CYC), .MIN_CYC(MIN_CYC)
) u_och_ctrl_monitor (
  .clk_sys, .arst_n, .enable_ok, .bias_supply_ok, .pwm_low_req, .sense_over,
  .low_gate_drive, .output_enable, .setpoint_source_en, .setpoint_code,
  .trip_threshold_code, .softstart_ref, .overcurrent_protection_off, .hiccup_active,
  .dummy_index, .min_pulse_active, .trip_pulse, .seq_state
);

`default_nettype wire

//--- tb/och_lsg_model.sv
`timescale 1ns/1ps
`default_nettype none

module och_lsg_model (
  // Clock
  input wire logic        clk_sys,
  // Gate and load
  input wire logic        low_gate_drive,
  input wire logic        short_on,
  // Set pin
  input wire logic [7:0]  set_level,
  input wire logic [7:0]  setpoint_code,
  // Sense outputs
  output var logic        sense_over,
  output logic            setpoint_reached
);
  // Registered so the drop and the gate never form a zero-delay loop
  always @(posedge clk_sys)
    sense_over <= short_on && low_gate_drive;

  assign setpoint_reached = setpoint_code >= set_level;
endmodule

`default_nettype wire

//--- tb/overcurrent_hiccup_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module overcurrent_hiccup_controller_tb_top;
  localparam int unsigned TB_CYC  = 2;
  localparam int unsigned SS_STEP = 4;
  localparam int          SS_CYC  = 64 * SS_STEP * TB_CYC;

  logic                clk_sys, arst_n, enable_ok, sw_period_start, pwm_low_req, short_on;
  logic                sense_over, setpoint_reached, low_gate_drive, output_enable;
  logic                setpoint_source_en, overcurrent_protection_off, hiccup_active;
  logic                dummy_index, min_pulse_active, trip_pulse;
  logic [7:0]          setpoint_code, set_level;
  logic [8:0]          trip_threshold_code;
  logic [6:0]          softstart_ref;
  logic [7:0]          per_cnt = 8'h00;
  logic                bias_supply_ok = 1'b1;
  och_pkg::och_state_t seq_state;
  int                  error_cnt = 0;
  int                  tests_run = 0;

  och_ctrl #(.TB_CYC(TB_CYC), .POR_TICKS(4), .SS_STEP_TICKS(SS_STEP)) u_och_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1), .bias_supply_ok(bias_supply_ok),
    .enable_ok(enable_ok), .setpoint_reached(setpoint_reached),
    .sw_period_start(sw_period_start), .pwm_low_req(pwm_low_req), .sense_over(sense_over),
    .low_gate_drive(low_gate_drive), .output_enable(output_enable),
    .setpoint_source_en(setpoint_source_en), .setpoint_code(setpoint_code),
    .trip_threshold_code(trip_threshold_code), .softstart_ref(softstart_ref),
    .overcurrent_protection_off(overcurrent_protection_off), .hiccup_active(hiccup_active),
    .dummy_index(dummy_index), .min_pulse_active(min_pulse_active),
    .trip_pulse(trip_pulse), .seq_state(seq_state)
  );

  och_lsg_model u_och_lsg_model (
    .clk_sys(clk_sys), .low_gate_drive(low_gate_drive), .short_on(short_on),
    .set_level(set_level), .setpoint_code(setpoint_code), .sense_over(sense_over),
    .setpoint_reached(setpoint_reached)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Switching period of 200 cycles, close to the real one at this clock
  always @(negedge clk_sys)
  begin
    per_cnt <= (per_cnt == 8'hC7) ? 8'h00 : per_cnt + 8'h01;
    sw_period_start <= per_cnt == 8'hC7;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wait_state(input och_pkg::och_state_t s, input int lim, output int n);
    n = 0;
    while (seq_state !== s && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("seq_state", s, seq_state);
  endtask

  task automatic wait_level(ref logic sig, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig === lvl && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  task automatic t_start();
    int n;
    wait_state(och_pkg::OCH_ST_POR_WAIT, 4, n);
    wait_state(och_pkg::OCH_ST_SAMPLE, 20, n);
    chk("por_cycles", 1, n >= 7 && n <= 10);
    chk("source_en", 1, setpoint_source_en);
    wait_state(och_pkg::OCH_ST_SOFTSTART, 600, n);
    chk("sample_cycles", 1, n >= 78 && n <= 90);
    chk("setpoint_code", 16'h28, setpoint_code);
    wait_state(och_pkg::OCH_ST_RUN, SS_CYC + 10, n);
    chk("ss_cycles", 1, n + 2 >= SS_CYC && n <= SS_CYC + 2);
    chk("softstart_ref", 16'h40, softstart_ref);
    chk("threshold", 16'h50, trip_threshold_code);
  endtask

  task automatic t_narrow();
    int n;
    wait_level(min_pulse_active, 1'b0, 800, n);
    wait_level(low_gate_drive, 1'b1, 100, n);
    chk("hold_width", 16'h0036, n[15:0]);
    wait_level(min_pulse_active, 1'b0, 800, n);
    chk("hold_spacing", 1, n >= 545 && n <= 547);
    wait_level(min_pulse_active, 1'b1, 100, n);
  endtask

  task automatic t_trip();
    int n;
    int m;
    logic [7:0] code;
    code = setpoint_code;
    // One edge must see the gate low, else the new pulse is no fresh rise
    @(negedge clk_sys);
    short_on = 1'b1;
    pwm_low_req = 1'b1;
    wait_level(output_enable, 1'b1, 100, n);
    chk("blank_cycles", 1, n >= 25 && n <= 26);
    @(negedge clk_sys);
    chk("trip_state", och_pkg::OCH_ST_DUMMY, seq_state);
    chk("hiccup_active", 1, hiccup_active);
    wait_state(och_pkg::OCH_ST_SOFTSTART, 2 * SS_CYC + 10, n);
    chk("dummy_cycles", 1, n + 3 >= 2 * SS_CYC && n <= 2 * SS_CYC + 3);
    wait_state(och_pkg::OCH_ST_DUMMY, 100, m);
    chk("hiccup_period", 1, n + m >= 2 * SS_CYC && n + m <= 3 * SS_CYC);
    chk("retry_retrip", 1, m >= 25 && m <= 27);
    chk("code_kept", code, setpoint_code);
    short_on = 1'b0;
    wait_state(och_pkg::OCH_ST_SOFTSTART, 2 * SS_CYC + 10, n);
    wait_state(och_pkg::OCH_ST_RUN, SS_CYC + 10, n);
    @(negedge clk_sys);
    chk("hiccup_cleared", 0, hiccup_active);
    pwm_low_req = 1'b0;
  endtask

  task automatic t_resample();
    int n;
    enable_ok = 1'b0;
    wait_state(och_pkg::OCH_ST_OFF, 4, n);
    chk("code_in_off", 16'h28, setpoint_code);
    set_level = 8'hC8;
    enable_ok = 1'b1;
    wait_state(och_pkg::OCH_ST_SOFTSTART, 700, n);
    chk("code_new", 16'hC8, setpoint_code);
    wait_state(och_pkg::OCH_ST_RUN, SS_CYC + 10, n);
    chk("protection_off", 1, overcurrent_protection_off);
    chk("threshold_clamp", 16'h130, trip_threshold_code);
    short_on = 1'b1;
    pwm_low_req = 1'b1;
    repeat (100) @(negedge clk_sys);
    chk("no_trip", och_pkg::OCH_ST_RUN, seq_state);
    short_on = 1'b0;
    pwm_low_req = 1'b0;
    // Losing the bias supply drops the stored set point
    bias_supply_ok = 1'b0;
    @(negedge clk_sys);
    chk("bias_loss_state", och_pkg::OCH_ST_OFF, seq_state);
    chk("code_bias_loss", 16'h00, setpoint_code);
    bias_supply_ok = 1'b1;
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    arst_n = 1'b0;
    enable_ok = 1'b1;
    pwm_low_req = 1'b0;
    short_on = 1'b0;
    set_level = 8'h28;
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    t_start();
    t_narrow();
    t_trip();
    t_resample();
    end_of_test();
  end

  // About 5300 cycles of work; the limit leaves ample room
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end
endmodule

`default_nettype wire
